// ===== core/mkbs_pkg.sv
package mkbs_pkg;
    localparam int X_N   = 8;
    localparam int Y_N   = 2;
    localparam int KEY_N = 16;
    localparam int BL_W  = 8;
    localparam int CNT_W = 16;
    localparam int TMR_W = 8;
    localparam int PER_W = 21;

    localparam int CLK_NS       = 8;
    localparam int DWELL_NS     = 250;
    localparam int CLAMP_NS     = 250;
    localparam int POST_NS      = 1000;
    localparam int PERIOD_NS    = 16_000_000;
    localparam int DWELL_CYC    = (DWELL_NS + CLK_NS - 1) / CLK_NS;
    localparam int CLAMP_CYC    = (CLAMP_NS + CLK_NS - 1) / CLK_NS;
    localparam int POST_CYC     = (POST_NS + CLK_NS - 1) / CLK_NS;
    localparam int PERIOD_CYC   = PERIOD_NS / CLK_NS;

    localparam logic [CNT_W-1:0] CNT_SAT   = 16'hFFFF;
    localparam logic [CNT_W-1:0] CNT_RST   = 16'h0000;
    localparam logic [X_N-1:0]   DRIVE_RST = 8'h00;
    localparam logic [Y_N-1:0]   CLAMP_RST = 2'h0;

    typedef enum logic [2:0] {
        MKBS_SLEEP,
        MKBS_PICK,
        MKBS_HIGH,
        MKBS_LOW,
        MKBS_POST,
        MKBS_RAMP
    } mkbs_state_t;

    typedef logic [KEY_N-1:0][BL_W-1:0] mkbs_bl_t;
endpackage

// ===== core/mkbs_ramp_if.sv
`timescale 1ns/1ps
interface mkbs_ramp_if;
    logic                         start;
    logic                         sel;
    logic                         done;
    logic [mkbs_pkg::CNT_W-1:0]   count;

    modport ctl (output start, output sel, input done, input count);
    modport tmr (input start, input sel, output done, output count);
endinterface

// ===== core/mkbs_ramp_timer.sv
`timescale 1ns/1ps
module mkbs_ramp_timer (
    input  wire logic                        core_clk_i,
    input  wire logic                        rstn_i,
    input  wire logic [mkbs_pkg::Y_N-1:0]    receive_line_ramp_pin_i,
    mkbs_ramp_if.tmr                         rif
);
    typedef struct packed {
        logic [mkbs_pkg::Y_N-1:0]   s1;
        logic [mkbs_pkg::Y_N-1:0]   s2;
        logic                       busy;
        logic                       sel;
        logic                       done;
        logic [mkbs_pkg::CNT_W-1:0] cnt;
    } mkbs_tmr_st_t;

    mkbs_tmr_st_t r_reg;
    mkbs_tmr_st_t r_next;

    always_comb
    begin
        r_next      = r_reg;
        r_next.s1   = receive_line_ramp_pin_i;
        r_next.s2   = r_reg.s1;
        r_next.done = 1'b0;
        if (rif.start)
        begin
            r_next.busy = 1'b1;
            r_next.sel  = rif.sel;
            r_next.cnt  = mkbs_pkg::CNT_RST;
        end
        else if (r_reg.busy)
        begin
            // Crossing ends the count; saturation ends it too
            if (r_reg.s2[r_reg.sel] || r_reg.cnt == mkbs_pkg::CNT_SAT)
            begin
                r_next.busy = 1'b0;
                r_next.done = 1'b1;
            end
            else
            begin
                r_next.cnt = r_reg.cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end

    assign rif.done  = r_reg.done;
    assign rif.count = r_reg.cnt;

    property p_sat_stop;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (r_reg.busy && !rif.start && r_reg.cnt == mkbs_pkg::CNT_SAT) |=> (rif.done && rif.count == 16'hFFFF);
    endproperty
    a_sat_stop: assert property (p_sat_stop) else $error("timer did not stop at saturation");

    property p_count_step;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (r_reg.busy && !rif.start && !r_reg.s2[r_reg.sel] && r_reg.cnt != mkbs_pkg::CNT_SAT)
            |=> (r_reg.cnt == $past(r_reg.cnt) + 16'h0001) && !rif.done;
    endproperty
    a_count_step: assert property (p_count_step) else $error("timer failed to count a cycle");
endmodule

// ===== core/mkbs_scanner.sv
// Notes on behaviour
// - Scan one key at a time, drive 0..7 on receive 0, then receive 1.
// - Key index is drive line plus eight times receive line.
// - Each key's burst has its own configured pulse count.
// - Finish a key's burst and its conversion before the next key starts.
// - Keys with zero pulse count are skipped and take no time slot.
// - Start a scan every 16 ms; sleep after the scan until then.
// - Clamp the active receive line on each falling drive edge.
// - After the burst clamp, then time the ramp to zero crossing.
// - Hold each drive pulse high at least 250 ns before clamping.
`timescale 1ns/1ps
module mkbs_scanner #(
    parameter int unsigned PERIOD_CYC = mkbs_pkg::PERIOD_CYC
) (
    input  wire logic                          core_clk_i,
    input  wire logic                          rstn_i,
    input  wire mkbs_pkg::mkbs_bl_t            burst_pulse_count_i,
    input  wire logic [mkbs_pkg::Y_N-1:0]      receive_line_ramp_pin_i,
    output logic      [mkbs_pkg::X_N-1:0]      drive_o,
    output logic      [mkbs_pkg::Y_N-1:0]      recv_clamp_oe_o,
    output logic      [mkbs_pkg::Y_N-1:0]      recv_clamp_out_o,
    output logic      [mkbs_pkg::CNT_W-1:0]    result_o,
    output logic      [3:0]                    result_key_o,
    output logic                               result_valid_o,
    output logic                               scan_active_o
);
    typedef struct packed {
        mkbs_pkg::mkbs_state_t          st;
        logic [4:0]                     key;
        logic [mkbs_pkg::BL_W-1:0]      pulse;
        logic [mkbs_pkg::TMR_W-1:0]     tmr;
        logic [mkbs_pkg::TMR_W-1:0]     hi_len;
        logic [mkbs_pkg::PER_W-1:0]     per;
        logic                           pend;
        logic                           start;
        logic [mkbs_pkg::X_N-1:0]       drive;
        logic [mkbs_pkg::Y_N-1:0]       clamp;
        logic [mkbs_pkg::Y_N-1:0]       clamp_lvl;
        logic [mkbs_pkg::CNT_W-1:0]     res;
        logic [3:0]                     res_key;
        logic                           res_valid;
        logic                           active;
    } mkbs_scan_st_t;

    localparam logic [mkbs_pkg::TMR_W-1:0] DWELL_LAST = 8'(mkbs_pkg::DWELL_CYC - 1);
    localparam logic [mkbs_pkg::TMR_W-1:0] CLAMP_LAST = 8'(mkbs_pkg::CLAMP_CYC - 1);
    localparam logic [mkbs_pkg::TMR_W-1:0] POST_LAST  = 8'(mkbs_pkg::POST_CYC - 1);
    localparam logic [mkbs_pkg::PER_W-1:0] PER_LAST   = 21'(PERIOD_CYC - 1);

    mkbs_scan_st_t              r_reg;
    mkbs_scan_st_t              r_next;
    logic [mkbs_pkg::KEY_N-1:0] key_en;
    logic                       found;
    logic [3:0]                 next_key;
    logic                       tick;

    mkbs_ramp_if u_rif ();

    mkbs_ramp_timer u_timer (
        .core_clk_i              (core_clk_i),
        .rstn_i                  (rstn_i),
        .receive_line_ramp_pin_i (receive_line_ramp_pin_i),
        .rif                     (u_rif.tmr)
    );

    assign u_rif.start = r_reg.start;
    assign u_rif.sel   = r_reg.key[3];

    // Key enabled when its pulse count is non-zero
    genvar g;
    generate
        for (g = 0; g < mkbs_pkg::KEY_N; g++)
        begin : g_en
            assign key_en[g] = |burst_pulse_count_i[g];
        end
    endgenerate

    // Lowest enabled key at or above the current index
    always_comb
    begin
        found    = 1'b0;
        next_key = 4'h0;
        for (int i = mkbs_pkg::KEY_N - 1; i >= 0; i--)
        begin
            if (key_en[i] && 5'(i) >= r_reg.key)
            begin
                found    = 1'b1;
                next_key = 4'(i);
            end
        end
    end

    assign tick = (r_reg.per == PER_LAST);

    always_comb
    begin
        r_next           = r_reg;
        r_next.start     = 1'b0;
        r_next.res_valid = 1'b0;
        r_next.per       = tick ? '0 : r_reg.per + 21'h000001;
        r_next.pend      = tick | r_reg.pend;
        // Length of the current drive pulse, checking only
        r_next.hi_len    = (|r_reg.drive) ? r_reg.hi_len + 8'h01 : '0;
        case (r_reg.st)
            mkbs_pkg::MKBS_SLEEP:
            begin
                if (r_reg.pend)
                begin
                    r_next.pend   = tick;
                    r_next.key    = 5'h00;
                    r_next.active = 1'b1;
                    r_next.st     = mkbs_pkg::MKBS_PICK;
                end
            end
            mkbs_pkg::MKBS_PICK:
            begin
                if (found)
                begin
                    r_next.key   = {1'b0, next_key};
                    r_next.pulse = '0;
                    r_next.tmr   = '0;
                    r_next.drive = 8'(8'h01 << next_key[2:0]);
                    r_next.st    = mkbs_pkg::MKBS_HIGH;
                end
                else
                begin
                    r_next.active = 1'b0;
                    r_next.st     = mkbs_pkg::MKBS_SLEEP;
                end
            end
            mkbs_pkg::MKBS_HIGH:
            begin
                r_next.tmr = r_reg.tmr + 8'h01;
                if (r_reg.tmr == DWELL_LAST)
                begin
                    r_next.tmr               = '0;
                    r_next.pulse             = r_reg.pulse + 8'h01;
                    r_next.drive             = mkbs_pkg::DRIVE_RST;
                    r_next.clamp[r_reg.key[3]] = 1'b1;
                    r_next.st                = mkbs_pkg::MKBS_LOW;
                end
            end
            mkbs_pkg::MKBS_LOW:
            begin
                r_next.tmr = r_reg.tmr + 8'h01;
                if (r_reg.tmr == CLAMP_LAST)
                begin
                    r_next.tmr = '0;
                    if (r_reg.pulse == burst_pulse_count_i[r_reg.key[3:0]])
                    begin
                        r_next.st = mkbs_pkg::MKBS_POST;
                    end
                    else
                    begin
                        r_next.clamp = mkbs_pkg::CLAMP_RST;
                        r_next.drive = 8'(8'h01 << r_reg.key[2:0]);
                        r_next.st    = mkbs_pkg::MKBS_HIGH;
                    end
                end
            end
            mkbs_pkg::MKBS_POST:
            begin
                r_next.tmr = r_reg.tmr + 8'h01;
                if (r_reg.tmr == POST_LAST)
                begin
                    r_next.tmr   = '0;
                    r_next.clamp = mkbs_pkg::CLAMP_RST;
                    r_next.start = 1'b1;
                    r_next.st    = mkbs_pkg::MKBS_RAMP;
                end
            end
            mkbs_pkg::MKBS_RAMP:
            begin
                if (u_rif.done)
                begin
                    r_next.res       = u_rif.count;
                    r_next.res_key   = r_reg.key[3:0];
                    r_next.res_valid = 1'b1;
                    r_next.key       = r_reg.key + 5'h01;
                    r_next.st        = mkbs_pkg::MKBS_PICK;
                end
            end
            default:
            begin
                r_next.st = mkbs_pkg::MKBS_SLEEP;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end

    assign drive_o          = r_reg.drive;
    assign recv_clamp_oe_o  = r_reg.clamp;
    assign recv_clamp_out_o = r_reg.clamp_lvl;
    assign result_o         = r_reg.res;
    assign result_key_o     = r_reg.res_key;
    assign result_valid_o   = r_reg.res_valid;
    assign scan_active_o    = r_reg.active;

    property p_row_drive;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (r_reg.st == mkbs_pkg::MKBS_HIGH) |-> (drive_o == 8'(8'h01 << r_reg.key[2:0]) && recv_clamp_oe_o == 2'h0);
    endproperty
    a_row_drive: assert property (p_row_drive) else $error("drive line does not match key");

    property p_key_order;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (r_reg.st == mkbs_pkg::MKBS_RAMP && u_rif.done) |=> ##1 (r_reg.st != mkbs_pkg::MKBS_HIGH || r_reg.key[3:0] > result_key_o);
    endproperty
    a_key_order: assert property (p_key_order) else $error("key order went backwards");

    property p_burst_len;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (r_reg.st == mkbs_pkg::MKBS_POST && $past(r_reg.st) != mkbs_pkg::MKBS_POST)
            |-> r_reg.pulse == burst_pulse_count_i[r_reg.key[3:0]];
    endproperty
    a_burst_len: assert property (p_burst_len) else $error("burst pulse count wrong");

    property p_convert;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (r_reg.st == mkbs_pkg::MKBS_RAMP && u_rif.done) |=> result_valid_o && result_o == $past(u_rif.count);
    endproperty
    a_convert: assert property (p_convert) else $error("result not posted after conversion");

    property p_skip;
        @(posedge core_clk_i) disable iff (!rstn_i)
        result_valid_o |-> burst_pulse_count_i[result_key_o] != 8'h00;
    endproperty
    a_skip: assert property (p_skip) else $error("disabled key was scanned");

    property p_period;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (r_reg.st == mkbs_pkg::MKBS_SLEEP && r_reg.pend) |=> (r_reg.st == mkbs_pkg::MKBS_PICK && scan_active_o);
    endproperty
    a_period: assert property (p_period) else $error("scan did not start on period");

    property p_clamp_low;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (r_reg.st == mkbs_pkg::MKBS_LOW || r_reg.st == mkbs_pkg::MKBS_POST)
            |-> (drive_o == 8'h00 && recv_clamp_oe_o == 2'(2'h1 << r_reg.key[3]));
    endproperty
    a_clamp_low: assert property (p_clamp_low) else $error("receive line not clamped");

    property p_post_start;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (r_reg.st == mkbs_pkg::MKBS_POST && r_reg.tmr == POST_LAST) |=> (u_rif.start && recv_clamp_oe_o == 2'h0);
    endproperty
    a_post_start: assert property (p_post_start) else $error("ramp timing not started");

    property p_dwell;
        @(posedge core_clk_i) disable iff (!rstn_i)
        $fell(|drive_o) |-> r_reg.hi_len > DWELL_LAST;
    endproperty
    a_dwell: assert property (p_dwell) else $error("drive pulse shorter than dwell");
endmodule

// ===== test/mkbs_matrix_model.sv
`timescale 1ns/1ps
module mkbs_matrix_model #(
    parameter int RAMP_BASE = 8,
    parameter int RAMP_STEP = 2
) (
    input  wire logic       core_clk_i,
    input  wire logic       rstn_i,
    input  wire logic [7:0] drive_i,
    input  wire logic [1:0] clamp_oe_i,
    input  wire logic       stuck_i,
    output logic      [1:0] ramp_pin_o
);
    logic [7:0] drive_prev;
    logic [1:0] oe_prev;
    logic [1:0] line;
    logic       armed;
    int         cnt;
    int         dly;
    int         pulses;

    // Charge builds per pulse; ramp time grows with pulse count
    always @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            drive_prev <= 8'h00;
            oe_prev    <= 2'h0;
            line       <= 2'h0;
            armed      <= 1'b0;
            cnt        <= 0;
            dly        <= 0;
            pulses     <= 0;
            ramp_pin_o <= 2'h0;
        end
        else
        begin
            drive_prev <= drive_i;
            oe_prev    <= clamp_oe_i;
            cnt        <= cnt + 1;
            if (drive_i != 8'h00 && drive_prev == 8'h00)
            begin
                pulses     <= pulses + 1;
                armed      <= 1'b0;
                ramp_pin_o <= 2'h0;
            end
            if (clamp_oe_i != 2'h0)
                ramp_pin_o <= 2'h0;
            if ((oe_prev & ~clamp_oe_i) != 2'h0 && drive_i == 8'h00)
            begin
                armed  <= 1'b1;
                line   <= oe_prev;
                cnt    <= 1;
                dly    <= RAMP_BASE + RAMP_STEP * pulses;
                pulses <= 0;
            end
            else if (armed && cnt >= dly && !stuck_i)
            begin
                ramp_pin_o <= line;
                armed      <= 1'b0;
            end
        end
    end
endmodule

// ===== test/mkbs_scanner_tb_top.sv
`timescale 1ns/1ps
module mkbs_scanner_tb_top;
    localparam int PER = 4000;
    logic               core_clk_i;
    logic               rstn_i = 1'b0;
    mkbs_pkg::mkbs_bl_t burst_pulse_count_i = 128'h01000000_00000003_01000000_02000001;
    logic               stuck = 1'b0;
    logic [1:0]         ramp_pin;
    logic [7:0]         drive_o;
    logic [1:0]         recv_clamp_oe_o;
    logic [1:0]         recv_clamp_out_o;
    logic [15:0]        result_o;
    logic [3:0]         result_key_o;
    logic               result_valid_o;
    logic               scan_active_o;
    logic [7:0]         prev_drive = 8'h00;
    logic [7:0]         last_drive = 8'h00;
    logic [1:0]         last_oe = 2'h0;
    logic               prev_act = 1'b0;
    int                 errors = 0;
    int                 comparisons = 0;
    int                 cyc = 0;
    int                 pulses = 0;
    int                 hi_len = 0;
    int                 act_len = 0;
    int                 act_w = 0;
    int                 bad = 0;
    int                 rk[$], rv[$], rp[$], rd[$], ro[$], starts[$];

    mkbs_scanner #(.PERIOD_CYC(PER)) u_dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
        .burst_pulse_count_i(burst_pulse_count_i), .receive_line_ramp_pin_i(ramp_pin),
        .drive_o(drive_o), .recv_clamp_oe_o(recv_clamp_oe_o), .recv_clamp_out_o(recv_clamp_out_o),
        .result_o(result_o), .result_key_o(result_key_o), .result_valid_o(result_valid_o),
        .scan_active_o(scan_active_o));
    mkbs_matrix_model u_model (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .drive_i(drive_o),
        .clamp_oe_i(recv_clamp_oe_o), .stuck_i(stuck), .ramp_pin_o(ramp_pin));

    initial
    begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end

    // Pin watcher: pulse counts, dwell, clamp placement, results
    always @(posedge core_clk_i)
    begin
        cyc++;
        if (rstn_i)
        begin
            if (drive_o != 8'h00 && prev_drive == 8'h00)
            begin
                pulses++;
                hi_len = 0;
                last_drive = drive_o;
            end
            if (drive_o != 8'h00)
                hi_len++;
            if (drive_o == 8'h00 && prev_drive != 8'h00)
            begin
                last_oe = recv_clamp_oe_o;
                if (hi_len < 32) bad++;
            end
            if ($countones(drive_o) > 1 || $countones(recv_clamp_oe_o) > 1) bad++;
            if (drive_o != 8'h00 && recv_clamp_oe_o != 2'h0) bad++;
            if ((recv_clamp_oe_o & recv_clamp_out_o) != 2'h0) bad++;
            if (!scan_active_o && (drive_o != 8'h00 || recv_clamp_oe_o != 2'h0)) bad++;
            if (result_valid_o === 1'b1)
            begin
                rk.push_back(result_key_o);
                rv.push_back(result_o);
                rp.push_back(pulses);
                rd.push_back(last_drive);
                ro.push_back(last_oe);
                pulses = 0;
            end
            if (scan_active_o && !prev_act) starts.push_back(cyc);
            act_len = scan_active_o ? act_len + 1 : 0;
            act_w = scan_active_o ? act_len : act_w;
        end
        prev_drive = drive_o;
        prev_act = scan_active_o;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        if (errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic wait_scan(input mkbs_pkg::mkbs_bl_t cfg, input int lim);
        int i;
        i = 0;
        @(posedge core_clk_i);
        burst_pulse_count_i <= cfg;
        rk.delete();
        rv.delete();
        rp.delete();
        rd.delete();
        ro.delete();
        while (scan_active_o !== 1'b1 && i < lim)
        begin
            @(negedge core_clk_i);
            i++;
        end
        while (scan_active_o !== 1'b0 && i < lim)
        begin
            @(negedge core_clk_i);
            i++;
        end
        check(i < lim, 1);
        repeat (3) @(negedge core_clk_i);
    endtask

    task automatic t_scan(input mkbs_pkg::mkbs_bl_t cfg);
        int n;
        n = 0;
        wait_scan(cfg, 2 * PER);
        for (int k = 0; k < 16; k++)
            if (cfg[k] != 8'h00)
            begin
                if (n < rk.size())
                begin
                    check(rk[n], k);
                    check(rp[n], cfg[k]);
                    check(rd[n], 1 << (k % 8));
                    check(ro[n], 1 << (k / 8));
                    check(rv[n] >= 8 + 2 * cfg[k] && rv[n] <= 13 + 2 * cfg[k], 1);
                end
                n++;
            end
        check(rk.size(), n);
        check(bad, 0);
    endtask

    task automatic t_period;
        check(starts.size() >= 2, 1);
        if (starts.size() >= 2)
            check(starts[1] - starts[0], PER);
    endtask

    task automatic t_empty;
        wait_scan('0, 2 * PER);
        check(rk.size(), 0);
        check(act_w, 1);
        check(bad, 0);
    endtask

    task automatic t_sat;
        @(posedge core_clk_i);
        stuck <= 1'b1;
        wait_scan(128'h00000000_00000000_00000100_00000000, 75000);
        check(rk.size(), 1);
        if (rk.size() == 1)
        begin
            check(rk[0], 5);
            check(rv[0], 16'hFFFF);
        end
    endtask

    initial
    begin
        repeat (10) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        t_scan(128'h01000000_00000003_01000000_02000001);
        t_scan({16{8'h01}});
        t_period();
        t_empty();
        t_sat();
        close_out();
    end

    initial
    begin
        #(90_000 * 8);
        errors++;
        close_out();
    end
endmodule
